/* File: logic/pcs_defs.vh */
// Purpose: Shared constants of the pin program configuration selector.
// Assumes: Register offsets are the byte addresses seen on the serial port.
// Notes:   Three-level straps arrive as two-bit codes from the pad comparators.
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

// Register offsets of the soft pin section.
`define PCS_ADDR_SECT1_EN     12'hc00
`define PCS_ADDR_FREQ_SEL     12'hc01
`define PCS_ADDR_SYSCLK_SEL   12'hc02
`define PCS_ADDR_SECT2_EN     12'hc03
`define PCS_ADDR_REF_SCALE    12'hc04
`define PCS_ADDR_CHAN_SCALE   12'hc05
`define PCS_ADDR_LOOP_OPT     12'hc06

// Reset values of the soft pin registers.
`define PCS_RST_SECT_EN       8'h00
`define PCS_RST_FREQ_SEL      8'h00
`define PCS_RST_SYSCLK_SEL    8'h00
`define PCS_RST_SCALE         8'h00
`define PCS_RST_LOOP_OPT      8'h00

// Field positions.
`define PCS_SECT_EN_BIT       0
`define PCS_IN_SEL_LSB        0
`define PCS_OUT_SEL_LSB       4
`define PCS_SYSCLK_LSB        0
`define PCS_TOL_LSB           0
`define PCS_BW_LSB            2
`define PCS_PM_BIT            4

// Three-level strap codes.
`define PCS_LVL_LOW           2'h0
`define PCS_LVL_MID           2'h1
`define PCS_LVL_HIGH          2'h2

// Scale codes and their division factors.
`define PCS_SCALE_DIV1        5'h01
`define PCS_SCALE_DIV4        5'h04
`define PCS_SCALE_DIV8        5'h08
`define PCS_SCALE_DIV16       5'h10

// System clock PLL feedback divider values.
`define PCS_SYS_N8            8'h08
`define PCS_SYS_N16           8'h10

`endif

/* File: logic/pcs_top.v */
// Purpose: Picks a preset frequency translation setup from straps or soft
//          registers and applies it to the device configuration outputs.
// Assumes: All inputs are synchronous to REF_CLK; the preset ROM and the
//          serial port engines sit outside and talk over the ports below.
// Notes:   Strap code 3 is read as low, as no pad ever drives it.
// Overview of operation
// [R1] Strap pin mode once after reset; high means hard pins, else soft registers.
// [R2] With the mode strap high, I2C accesses are dropped; SPI keeps full access.
// [R3] Hard mode: three input straps and three output straps pick 16 frequencies each.
// [R4] Output id is 9*upper+3*middle+lower of tri-level digits; soft uses binary nibble.
// [R5] Hard mode: interrupt pin level low/mid/high picks system clock 0/1/2.
// [R6] Settings 0..3: crystal on/off/on/off; doubler off only in 3; N=16 only in 2.
// [R7] Hard mode leaves bandwidth, tolerance and phase margin at register values.
// [R8] Host sets multifunction pin enable itself in hard mode; not handled here.
// [R9] Soft mode is driven by the soft register section; both serial ports work.
// [R10] First section enable bit gates the frequency and system clock registers.
// [R11] Second section enable bit gates the scale and loop option registers.
// [R12] Frequency select: low nibble input id, high nibble output id.
// [R13] System clock select register low two bits pick setting 0..3.
// [R14] Loop option bits 1:0 pick the frequency tolerance range.
// [R15] Loop option bits 3:2 pick the loop bandwidth.
// [R16] Loop option bit 4 picks the phase margin.
// [R17] Reference scale code 01 multiplies divider and period by four.
// [R18] Channel scale register divides each of four outputs independently.
// [R19] After start the chosen preset is copied out to the configuration outputs.
// [R20] Scale codes 00/01/10/11 mean divide by 1/4/8/16.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defs.vh"

module pcs_top (
    // Clock and reset.
    input  wire        REF_CLK,
    input  wire        RST_B,
    // Strap pins; all but the one-bit mode strap as two-bit level codes.
    // Code 3 cannot come from a pad and is read as low.
    input  wire        PIN_MODE_STRAP,
    input  wire [1:0]  INPUT_SEL_STRAP_A,
    input  wire [1:0]  INPUT_SEL_STRAP_B,
    input  wire [1:0]  INPUT_SEL_STRAP_C,
    input  wire [1:0]  OUTPUT_SEL_STRAP_UPPER,
    input  wire [1:0]  OUTPUT_SEL_STRAP_MIDDLE,
    input  wire [1:0]  OUTPUT_SEL_STRAP_LOWER,
    input  wire [1:0]  IRQ_PIN_LEVEL,
    // Register port from the serial engines.
    input  wire [11:0] REG_ADDR,
    input  wire [7:0]  REG_WDATA,
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire        REG_FROM_I2C,
    output reg  [7:0]  REG_RDATA,
    output reg         REG_RVALID,
    // Load request from software, taken in soft or hard mode.
    input  wire        PIN_PROG_START,
    // Mode status.
    output reg         HARD_PIN_MODE,
    output reg         I2C_ENABLE,
    output reg         LOAD_BUSY,
    // Applied configuration.
    output reg         CFG_LOAD,
    output reg  [7:0]  ROM_ADDR,
    output reg  [1:0]  SYSCLK_SETTING,
    output reg         CRYSTAL_MODE,
    output reg         SYSCLK_DOUBLER,
    output reg  [7:0]  SYSCLK_N,
    output reg  [1:0]  TOLERANCE_SEL,
    output reg  [1:0]  LOOP_BW_SEL,
    output reg         PHASE_MARGIN_SEL,
    output reg  [19:0] REF_SCALE_FACTOR,
    output reg  [19:0] CHAN_SCALE_FACTOR
);

    // Loader states. SAMPLE is only entered from reset, so the straps are
    // read exactly once after each reset.
    localparam [1:0] ST_SAMPLE = 2'h0;
    localparam [1:0] ST_IDLE   = 2'h1;
    localparam [1:0] ST_LOAD   = 2'h2;
    localparam [1:0] ST_DONE   = 2'h3;

    // Loader state and its next value.
    reg  [1:0] state;
    reg  [1:0] next_state;

    // Soft pin section registers as the host last wrote them.
    reg  [7:0] sect1_en;
    reg  [7:0] freq_sel;
    reg  [7:0] sysclk_sel;
    reg  [7:0] sect2_en;
    reg  [7:0] ref_scale;
    reg  [7:0] chan_scale;
    reg  [7:0] loop_opt;

    // Strap decode results, frozen until the next reset.
    reg  [3:0] strap_in_id;
    reg  [3:0] strap_out_id;
    reg  [1:0] strap_sysclk;

    // Turns one three-level strap code into its digit 0, 1 or 2.
    // Code 3 is no legal pad state; it falls to low, never to an unused id.
    function [3:0] tri_digit;
        input [1:0] lvl;
        begin
            case (lvl)
                `PCS_LVL_MID:  tri_digit = 4'h1;
                `PCS_LVL_HIGH: tri_digit = 4'h2;
                default:       tri_digit = 4'h0;
            endcase
        end
    endfunction

    // Base-three identifier from three strap digits, highest first. The sum
    // reaches 26 with every strap high; only its low four bits index the
    // preset table, so the top combinations fold back onto lower ids.
    function [3:0] tri_id;
        input [1:0] hi;
        input [1:0] mid;
        input [1:0] lo;
        reg   [7:0] sum;
        begin
            sum    = {4'h0, tri_digit(hi)} * 8'h09
                   + {4'h0, tri_digit(mid)} * 8'h03
                   + {4'h0, tri_digit(lo)};
            tri_id = sum[3:0];
        end
    endfunction

    // Division factor of one two-bit scale code.
    // Code 00 leaves the frequency as the preset gives it.
    function [4:0] scale_factor;
        input [1:0] code;
        begin
            case (code)
                2'h1:    scale_factor = `PCS_SCALE_DIV4;
                2'h2:    scale_factor = `PCS_SCALE_DIV8;
                2'h3:    scale_factor = `PCS_SCALE_DIV16;
                default: scale_factor = `PCS_SCALE_DIV1;
            endcase
        end
    endfunction

    // Four packed factors, one per reference or channel.
    function [19:0] scale_vector;
        input [7:0] codes;
        begin
            scale_vector = {scale_factor(codes[7:6]), scale_factor(codes[5:4]),
                            scale_factor(codes[3:2]), scale_factor(codes[1:0])};
        end
    endfunction

    // Access gating shared by reads and writes. The I2C refusal follows the
    // latched mode, so it only takes hold after the strap sample cycle.
    wire port_ok  = ~(HARD_PIN_MODE & REG_FROM_I2C);
    wire sect1_ok = sect1_en[`PCS_SECT_EN_BIT];
    wire sect2_ok = sect2_en[`PCS_SECT_EN_BIT];
    wire wr_ok    = REG_WR & port_ok;

    // Effective selections feeding the next load.
    // Soft mode reads the section registers, which hold still between writes.
    wire [3:0] in_id   = HARD_PIN_MODE ? strap_in_id : freq_sel[`PCS_IN_SEL_LSB +: 4];
    wire [3:0] out_id  = HARD_PIN_MODE ? strap_out_id : freq_sel[`PCS_OUT_SEL_LSB +: 4];
    wire [1:0] sys_sel = HARD_PIN_MODE ? strap_sysclk : sysclk_sel[`PCS_SYSCLK_LSB +: 2];

    // Digit of the interrupt pin level. It never exceeds two, which is why
    // system clock setting 3 is out of reach of the pins.
    wire [3:0] irq_digit = tri_digit(IRQ_PIN_LEVEL);

    // Straps are caught by a clocked process in the first cycle after reset,
    // so reset itself only loads constants.
    // A strap that moves later goes unnoticed until the next reset.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            HARD_PIN_MODE <= 1'b0;
            I2C_ENABLE    <= 1'b1;
            strap_in_id   <= 4'h0;
            strap_out_id  <= 4'h0;
            strap_sysclk  <= 2'h0;
        end else if (state == ST_SAMPLE) begin
            // [R1] one-time mode sample
            HARD_PIN_MODE <= PIN_MODE_STRAP;
            // [R2] I2C off in hard
            I2C_ENABLE    <= ~PIN_MODE_STRAP;
            // [R3] input strap select
            strap_in_id   <= tri_id(INPUT_SEL_STRAP_B, INPUT_SEL_STRAP_C, INPUT_SEL_STRAP_A);
            // [R4] tri-level output id
            strap_out_id  <= tri_id(OUTPUT_SEL_STRAP_UPPER, OUTPUT_SEL_STRAP_MIDDLE,
                                    OUTPUT_SEL_STRAP_LOWER);
            // [R5] interrupt pin setting; setting 3 unreachable from pins
            strap_sysclk  <= irq_digit[1:0];
        end
    end

    // Soft pin register writes. Gated fields ignore writes while their
    // section enable is clear, which keeps a half-set selection from leaking.
    // The enable registers are never gated, or a section could not be opened.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sect1_en   <= `PCS_RST_SECT_EN;
            sect2_en   <= `PCS_RST_SECT_EN;
            freq_sel   <= `PCS_RST_FREQ_SEL;
            sysclk_sel <= `PCS_RST_SYSCLK_SEL;
            ref_scale  <= `PCS_RST_SCALE;
            chan_scale <= `PCS_RST_SCALE;
            loop_opt   <= `PCS_RST_LOOP_OPT;
        end else if (wr_ok) begin
            case (REG_ADDR)
                // [R9] soft section writes
                `PCS_ADDR_SECT1_EN: sect1_en <= REG_WDATA;
                `PCS_ADDR_SECT2_EN: sect2_en <= REG_WDATA;
                // [R10] section one gating
                `PCS_ADDR_FREQ_SEL: begin
                    if (sect1_ok) begin
                        freq_sel <= REG_WDATA;
                    end
                end
                `PCS_ADDR_SYSCLK_SEL: begin
                    if (sect1_ok) begin
                        sysclk_sel <= REG_WDATA;
                    end
                end
                // [R11] section two gating
                `PCS_ADDR_REF_SCALE: begin
                    if (sect2_ok) begin
                        ref_scale <= REG_WDATA;
                    end
                end
                `PCS_ADDR_CHAN_SCALE: begin
                    if (sect2_ok) begin
                        chan_scale <= REG_WDATA;
                    end
                end
                `PCS_ADDR_LOOP_OPT: begin
                    if (sect2_ok) begin
                        loop_opt <= REG_WDATA;
                    end
                end
                // Unmapped offsets are ignored.
                default: ;
            endcase
        end
    end

    // Register reads answer one cycle later; gated, unmapped or refused
    // accesses read as zero so software never sees stale state.
    // Every read is answered, refused or not, so the host never waits.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            REG_RDATA  <= 8'h00;
            if (REG_RD && port_ok) begin
                case (REG_ADDR)
                    `PCS_ADDR_SECT1_EN:   REG_RDATA <= sect1_en;
                    `PCS_ADDR_SECT2_EN:   REG_RDATA <= sect2_en;
                    `PCS_ADDR_FREQ_SEL:   REG_RDATA <= sect1_ok ? freq_sel : 8'h00;
                    `PCS_ADDR_SYSCLK_SEL: REG_RDATA <= sect1_ok ? sysclk_sel : 8'h00;
                    `PCS_ADDR_REF_SCALE:  REG_RDATA <= sect2_ok ? ref_scale : 8'h00;
                    `PCS_ADDR_CHAN_SCALE: REG_RDATA <= sect2_ok ? chan_scale : 8'h00;
                    `PCS_ADDR_LOOP_OPT:   REG_RDATA <= sect2_ok ? loop_opt : 8'h00;
                    default:              REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Loader sequence: sample straps, load once in hard mode, then wait for
    // a software start to reload, from the soft section in soft mode and from the latched straps in hard mode.
    // A start outside idle is ignored, so a load always copies one snapshot
    // of the section rather than a mix of old and new fields.
    always @* begin
        next_state = state;
        case (state)
            ST_SAMPLE: next_state = PIN_MODE_STRAP ? ST_LOAD : ST_IDLE;
            ST_IDLE:   next_state = PIN_PROG_START ? ST_LOAD : ST_IDLE;
            ST_LOAD:   next_state = ST_DONE;
            ST_DONE:   next_state = ST_IDLE;
            default:   next_state = ST_SAMPLE;
        endcase
    end

    // State register. Reset returns to the strap sample, so a mid-run reset
    // reads the straps again.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= ST_SAMPLE;
        end else begin
            state <= next_state;
        end
    end

    // Applied configuration. Outputs only move on a load so downstream
    // logic never sees a selection that is still being typed in.
    // During reset the outputs show setting 0 with unity scaling, a safe
    // default until the first load.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CFG_LOAD          <= 1'b0;
            LOAD_BUSY         <= 1'b1;
            ROM_ADDR          <= 8'h00;
            SYSCLK_SETTING    <= 2'h0;
            CRYSTAL_MODE      <= 1'b1;
            SYSCLK_DOUBLER    <= 1'b1;
            SYSCLK_N          <= `PCS_SYS_N8;
            TOLERANCE_SEL     <= 2'h0;
            LOOP_BW_SEL       <= 2'h0;
            PHASE_MARGIN_SEL  <= 1'b0;
            REF_SCALE_FACTOR  <= {4{`PCS_SCALE_DIV1}};
            CHAN_SCALE_FACTOR <= {4{`PCS_SCALE_DIV1}};
        end else begin
            CFG_LOAD  <= (state == ST_LOAD);
            LOAD_BUSY <= (next_state == ST_LOAD) || (next_state == ST_SAMPLE);
            // Every field below moves only in the load cycle.
            if (state == ST_LOAD) begin
                // [R19] preset copy out
                // [R12] nibble ids form ROM index
                ROM_ADDR       <= {out_id, in_id};
                // [R13] system clock setting
                SYSCLK_SETTING <= sys_sel;
                // [R6] clock setting fields
                CRYSTAL_MODE   <= (sys_sel == 2'h0) || (sys_sel == 2'h2);
                SYSCLK_DOUBLER <= (sys_sel != 2'h3);
                SYSCLK_N       <= (sys_sel == 2'h2) ? `PCS_SYS_N16 : `PCS_SYS_N8;
                // [R7] loop options from registers
                // [R14] tolerance range
                TOLERANCE_SEL    <= loop_opt[`PCS_TOL_LSB +: 2];
                // [R15] loop bandwidth
                LOOP_BW_SEL      <= loop_opt[`PCS_BW_LSB +: 2];
                // [R16] phase margin
                PHASE_MARGIN_SEL <= loop_opt[`PCS_PM_BIT];
                // Hard mode has no scaling straps, so every factor is one there.
                // [R17] reference scaling
                // [R20] code to factor
                REF_SCALE_FACTOR <= HARD_PIN_MODE ? {4{`PCS_SCALE_DIV1}}
                                                  : scale_vector(ref_scale);
                // [R18] channel scaling
                CHAN_SCALE_FACTOR <= HARD_PIN_MODE ? {4{`PCS_SCALE_DIV1}}
                                                   : scale_vector(chan_scale);
            end
        end
    end

endmodule // pcs_top

`default_nettype wire

/* File: bench/pcs_host.sv */
// Purpose: Serial host model that drives the register port of the selector.
// Assumes: One byte access per call, launched just after a rising edge.
// Notes:   Released address and data lines carry inverted values.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defs.vh"
module pcs_host (
    // Clock.
    input  wire logic        clk,
    // Register port.
    output var  logic [11:0] addr,
    output var  logic [7:0]  wdata,
    output var  logic        wr,
    output var  logic        rd,
    output var  logic        i2c,
    input  wire logic [7:0]  rdata
);
    // Idle port at time zero.
    initial begin
        {addr, wdata, wr, rd, i2c} = '0;
    end
    // Held for the single edge that takes it, so no stale value lingers.
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d,
             input logic s, output logic [7:0] q);
        @(posedge clk);
        {addr, wdata, i2c, wr, rd} <= {a, d, s, w, ~w};
        @(posedge clk);
        {addr, wdata, wr, rd} <= {~a, ~d, 2'b00};
        #1 q = rdata;
    endtask
    task sections;
        logic [7:0] q;
        acc(1'b1, `PCS_ADDR_SECT1_EN, 8'h01, 1'b0, q);
        acc(1'b1, `PCS_ADDR_SECT2_EN, 8'h01, 1'b0, q);
    endtask
endmodule // pcs_host
`default_nettype wire

/* File: bench/pcs_assertions.sv */
// Purpose: Port-level timing checks of the configuration selector.
// Assumes: One clock domain; bound to every pcs_top instance.
// Notes:   A saturating edge counter marks the power-up strap sample.
`timescale 1ns/100ps
`default_nettype none
module pcs_checker (
    // Clock and reset.
    input wire logic       REF_CLK,
    input wire logic       RST_B,
    // Register port.
    input wire logic       REG_RD,
    input wire logic       REG_FROM_I2C,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    // Mode and load.
    input wire logic       PIN_PROG_START,
    input wire logic       HARD_PIN_MODE,
    input wire logic       I2C_ENABLE,
    input wire logic       LOAD_BUSY,
    input wire logic       CFG_LOAD,
    // System clock outputs.
    input wire logic [1:0] SYSCLK_SETTING,
    input wire logic       CRYSTAL_MODE,
    input wire logic       SYSCLK_DOUBLER,
    input wire logic [7:0] SYSCLK_N
);
    logic [1:0] cyc;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // Edges since release; saturates so later edges never wrap.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            cyc <= 2'h0;
        else if (cyc != 2'h3)
            cyc <= cyc + 2'h1;
    end
    // A start taken in idle gives one busy cycle, then a one-cycle pulse.
    sequence s_take; PIN_PROG_START && !LOAD_BUSY && !CFG_LOAD; endsequence
    sequence s_apply; LOAD_BUSY ##1 CFG_LOAD && !LOAD_BUSY ##1 !CFG_LOAD; endsequence
    property p_load; s_take |=> s_apply; endproperty
    a_load: assert property (p_load) else $error("load timing wrong");
    property p_hard_load; cyc == 2'h1 && HARD_PIN_MODE |=> CFG_LOAD; endproperty
    a_hard_load: assert property (p_hard_load) else $error("no power-up load");
    property p_mode_once; cyc >= 2'h2 |-> $stable(HARD_PIN_MODE); endproperty
    a_mode_once: assert property (p_mode_once) else $error("mode changed");
    property p_i2c_en; I2C_ENABLE == !HARD_PIN_MODE; endproperty
    a_i2c_en: assert property (p_i2c_en) else $error("i2c enable wrong");
    property p_i2c_drop; HARD_PIN_MODE && REG_RD && REG_FROM_I2C |=> REG_RDATA == 8'h00;
    endproperty
    a_i2c_drop: assert property (p_i2c_drop) else $error("i2c read served");
    property p_rvalid; REG_RD |=> REG_RVALID ##1 !REG_RVALID; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer wrong");
    property p_rdata_idle; !REG_RVALID |-> REG_RDATA == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data stale");
    property p_sys; CFG_LOAD |-> CRYSTAL_MODE == !SYSCLK_SETTING[0]
        && SYSCLK_DOUBLER == (SYSCLK_SETTING != 2'h3)
        && SYSCLK_N == ((SYSCLK_SETTING == 2'h2) ? 8'h10 : 8'h08); endproperty
    a_sys: assert property (p_sys) else $error("system clock setup wrong");
endmodule // pcs_checker
bind pcs_top pcs_checker u_chk (.REF_CLK, .RST_B, .REG_RD, .REG_FROM_I2C,
    .REG_RDATA, .REG_RVALID, .PIN_PROG_START, .HARD_PIN_MODE, .I2C_ENABLE,
    .LOAD_BUSY, .CFG_LOAD, .SYSCLK_SETTING, .CRYSTAL_MODE, .SYSCLK_DOUBLER,
    .SYSCLK_N);
`default_nettype wire

/* File: bench/pcs_top_bench.sv */
// Purpose: Self-checking bench of the configuration selector.
// Assumes: Straps settle before reset release and stay put.
// Notes:   Random values come from an LFSR with a fixed start.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defs.vh"
module pcs_top_bench;
    logic        clk, rst_b, strap, start;
    logic [1:0]  sa, sb, sc, su, sm, sl, irq;
    logic [7:0]  q;
    logic [31:0] seed;
    integer      i, n_fail, cmp_count;
    wire  [11:0] addr;
    wire  [7:0]  wdata, rdata, rom, n;
    wire         wr, rd, i2c, hard, i2ce, cfg, crystal_mode, dbl, pm;
    wire  [1:0]  sys, tol, bw;
    wire  [19:0] rsf, csf;
    // Design and host model.
    pcs_top dut (.REF_CLK(clk), .RST_B(rst_b), .PIN_MODE_STRAP(strap),
        .INPUT_SEL_STRAP_A(sa), .INPUT_SEL_STRAP_B(sb), .INPUT_SEL_STRAP_C(sc),
        .OUTPUT_SEL_STRAP_UPPER(su), .OUTPUT_SEL_STRAP_MIDDLE(sm),
        .OUTPUT_SEL_STRAP_LOWER(sl), .IRQ_PIN_LEVEL(irq), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_FROM_I2C(i2c),
        .REG_RDATA(rdata), .REG_RVALID(), .PIN_PROG_START(start),
        .HARD_PIN_MODE(hard), .I2C_ENABLE(i2ce), .LOAD_BUSY(), .CFG_LOAD(cfg),
        .ROM_ADDR(rom), .SYSCLK_SETTING(sys), .CRYSTAL_MODE(crystal_mode),
        .SYSCLK_DOUBLER(dbl), .SYSCLK_N(n), .TOLERANCE_SEL(tol), .LOOP_BW_SEL(bw),
        .PHASE_MARGIN_SEL(pm), .REF_SCALE_FACTOR(rsf), .CHAN_SCALE_FACTOR(csf));
    pcs_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .i2c(i2c), .rdata(rdata));
    // Clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // The whole run needs under two hundred cycles; this leaves ample margin.
    initial begin
        #100000;
        n_fail++;
        conclude;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Code 3 maps to high so an all-ones draw puts every strap high.
    function automatic logic [1:0] tl(input logic [1:0] x);
        tl = (x == 2'h3) ? 2'h2 : x;
    endfunction
    function automatic logic [9:0] esys(input logic [1:0] s);
        esys = {~s[0], s != 2'h3, (s == 2'h2) ? 8'h10 : 8'h08};
    endfunction
    function automatic logic [19:0] escl(input logic [7:0] c);
        integer k;
        for (k = 0; k < 4; k++)
            escl[k*5 +: 5] = 5'h01 << ((c[k*2 +: 2] == 2'h0) ? 0 : c[k*2 +: 2] + 1);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reset with straps set; returns two edges after release.
    task do_reset(input logic hm, input logic [1:0] lv, input logic [11:0] d);
        @(posedge clk);
        rst_b <= 1'b0;
        {strap, irq} <= {hm, lv};
        {sa, sb, sc} <= {tl(d[1:0]), tl(d[3:2]), tl(d[5:4])};
        {su, sm, sl} <= {tl(d[7:6]), tl(d[9:8]), tl(d[11:10])};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task wait_cfg;
        integer k;
        for (k = 0; k < 6 && cfg !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(cfg, 1'b1);
    endtask
    task load;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        wait_cfg;
    endtask
    // Main sequence: hard mode at each interrupt level, then soft mode.
    initial begin
        {rst_b, strap, start, sa, sb, sc, su, sm, sl, irq} = '0;
        {n_fail, cmp_count} = '0;
        seed = 32'h1f44;
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            do_reset(1'b1, i[1:0], (i == 0) ? 12'hfff : seed[11:0]);
            wait_cfg;
            chk({hard, i2ce}, 2'b10);
            chk(rom, {4'(9*su + 3*sm + sl), 4'(9*sb + 3*sc + sa)});
            chk(sys, i);
            chk({crystal_mode, dbl, n}, esys(i[1:0]));
        end
        host.acc(1'b1, `PCS_ADDR_SECT1_EN, 8'h01, 1'b1, q);
        host.acc(1'b0, `PCS_ADDR_SECT1_EN, 8'h00, 1'b0, q);
        chk(q, 8'h00);
        host.sections;
        host.acc(1'b0, `PCS_ADDR_SECT1_EN, 8'h00, 1'b1, q);
        chk(q, 8'h00);
        host.acc(1'b0, `PCS_ADDR_SECT1_EN, 8'h00, 1'b0, q);
        chk(q, 8'h01);
        host.acc(1'b1, 12'h200, 8'h01, 1'b0, q);
        host.acc(1'b0, 12'h200, 8'h00, 1'b0, q);
        chk(q, 8'h00);
        host.acc(1'b1, `PCS_ADDR_LOOP_OPT, 8'h1b, 1'b0, q);
        load;
        chk({pm, bw, tol, sys}, 7'h6e);
        do_reset(1'b0, 2'h0, 12'h000);
        chk({hard, i2ce}, 2'b01);
        for (i = 0; i < 7; i++) begin
            host.acc(1'b1, `PCS_ADDR_SECT1_EN + 12'(i), 8'h5a, 1'b0, q);
            host.acc(1'b0, `PCS_ADDR_SECT1_EN + 12'(i), 8'h00, 1'b0, q);
            chk(q, (i == 0 || i == 3) ? 8'h5a : 8'h00);
        end
        host.sections;
        host.acc(1'b0, `PCS_ADDR_FREQ_SEL, 8'h00, 1'b0, q);
        chk(q, 8'h00);
        host.acc(1'b0, `PCS_ADDR_LOOP_OPT, 8'h00, 1'b0, q);
        chk(q, 8'h00);
        do_reset(1'b0, 2'h0, 12'h000);
        host.sections;
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            host.acc(1'b1, `PCS_ADDR_FREQ_SEL, seed[7:0], seed[8], q);
            host.acc(1'b1, `PCS_ADDR_SYSCLK_SEL, {seed[15:10], i[1:0]}, 1'b0, q);
            host.acc(1'b1, `PCS_ADDR_REF_SCALE, seed[23:16], 1'b0, q);
            host.acc(1'b1, `PCS_ADDR_CHAN_SCALE, seed[31:24], 1'b1, q);
            host.acc(1'b1, `PCS_ADDR_LOOP_OPT, {3'h0, seed[20:16]}, 1'b0, q);
            host.acc(1'b0, `PCS_ADDR_FREQ_SEL, 8'h00, 1'b1, q);
            chk(q, seed[7:0]);
            load;
            chk(rom, seed[7:0]);
            chk({sys, crystal_mode, dbl, n}, {i[1:0], esys(i[1:0])});
            chk(rsf, escl(seed[23:16]));
            chk(csf, escl(seed[31:24]));
            chk({pm, bw, tol}, seed[20:16]);
        end
        conclude;
    end
endmodule // pcs_top_bench
`default_nettype wire
